// ### design/segment_address_translation.sv
`timescale 1ns/1ns
`include "seg_xlat_params.svh"
module segment_address_translation
  import seg_xlat_pkg::*;
#(
  parameter int NUM_SEGS = 10
)(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic mode_req_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic load_in,
  input wire logic [1:0] load_kind_in,
  input wire logic [3:0] load_seg_in,
  input wire logic [15:0] load_sel_in,
  input wire logic [63:0] load_base_in,
  input wire logic [31:0] load_limit_in,
  input wire logic [11:0] load_attr_in,
  input wire logic access_in,
  input wire logic [3:0] access_seg_in,
  input wire logic [63:0] eff_addr_in,
  output logic [1:0] mode_out,
  output logic addr_valid_out,
  output logic [63:0] lin_addr_out,
  output logic limit_fault_out,
  output logic load_err_out
);
  logic [1:0] mode_q;
  logic [15:0] sel_q [NUM_SEGS];
  logic [63:0] base_q [NUM_SEGS];
  logic [31:0] limit_q [NUM_SEGS];
  logic [11:0] attr_q [NUM_SEGS];
  logic real_mode;
  logic is_user;
  logic is_far;
  logic load_ok;
  logic [15:0] cur_sel;
  logic [63:0] cur_base;
  logic [31:0] cur_limit;
  logic [11:0] cur_attr;
  logic flat_base;
  logic [63:0] lin_d;
  logic fault_d;

  assign real_mode = cpu_mode_t'(mode_q) == MODE_REAL;
  assign is_user = load_seg_in <= 4'(SEG_STACK);
  assign is_far = load_kind_t'(load_kind_in) == LOAD_FAR;
  always_comb begin
    load_ok = 1'b0;
    if (load_in && load_seg_in < 4'(NUM_SEGS)) begin
      unique case (load_kind_t'(load_kind_in))
        LOAD_SELECTOR: load_ok = is_user && load_seg_in != 4'(SEG_CODE);
        LOAD_FAR: load_ok = load_seg_in == 4'(SEG_CODE);
        LOAD_DESCRIPTOR: load_ok = !real_mode;
        LOAD_NONE: load_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= 2'(MODE_REAL);
    end else if (mode_req_in) begin
      if (real_mode) begin
        if (cpu_mode_t'(mode_sel_in) == MODE_PROT) begin
          mode_q <= mode_sel_in;
        end
      end else begin
        mode_q <= mode_sel_in;
      end
    end
  end

  generate
    for (genvar i = 0; i < NUM_SEGS; i++) begin : g_seg
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          sel_q[i] <= (i == 0) ? `SEG_RST_CODE_SEL : 16'h0000;
          base_q[i] <= (i == 0) ? `SEG_RST_CODE_BASE : 64'h0;
          limit_q[i] <= `SEG_RST_LIMIT;
          attr_q[i] <= `SEG_RST_ATTR;
        end else if (load_ok && load_seg_in == 4'(i)) begin
          if (real_mode) begin
            sel_q[i] <= load_sel_in;
            base_q[i] <= {44'h0, load_sel_in, 4'h0};
          end else begin
            sel_q[i] <= load_sel_in;
            base_q[i] <= load_base_in;
            limit_q[i] <= load_limit_in;
            attr_q[i] <= load_attr_in;
          end
        end
      end
    end
  endgenerate
  // apart from reset, limit and attributes are only written on the protected path above

  always_comb begin
    cur_sel = 16'h0;
    cur_base = 64'h0;
    cur_limit = 32'h0;
    cur_attr = 12'h0;
    for (int k = 0; k < NUM_SEGS; k++) begin
      if (access_seg_in == 4'(k)) begin
        cur_sel = sel_q[k];
        cur_base = base_q[k];
        cur_limit = limit_q[k];
        cur_attr = attr_q[k];
      end
    end
    // load in the same cycle overrides the stored copy
    if (load_ok && load_seg_in == access_seg_in) begin
      cur_sel = load_sel_in;
      if (real_mode) begin
        cur_base = {44'h0, load_sel_in, 4'h0};
      end else begin
        cur_base = load_base_in;
        cur_limit = load_limit_in;
        cur_attr = load_attr_in;
      end
    end
    flat_base = !(access_seg_in == 4'(SEG_ADD_ONE) || access_seg_in == 4'(SEG_ADD_TWO) ||
      access_seg_in >= 4'(SEG_GDT));
  end

  seg_addr_adder u_adder (
    .mode_in(mode_q),
    .selector_in(cur_sel),
    .base_in(cur_base),
    .limit_in(cur_limit),
    .attr_db_in(cur_attr[`SEG_ATTR_DB_BIT]),
    .flat_base_in(flat_base),
    .eff_addr_in(eff_addr_in),
    .lin_addr_out(lin_d),
    .limit_fault_out(fault_d)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      addr_valid_out <= 1'b0;
      lin_addr_out <= 64'h0;
      limit_fault_out <= 1'b0;
    end else begin
      addr_valid_out <= access_in && access_seg_in < 4'(NUM_SEGS);
      lin_addr_out <= lin_d;
      limit_fault_out <= access_in && fault_d;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      load_err_out <= 1'b0;
    end else begin
      load_err_out <= load_in && !load_ok;
    end
  end

  assign mode_out = mode_q;
endmodule

// ### design/seg_xlat_params.svh
`ifndef SEG_XLAT_PARAMS_SVH
`define SEG_XLAT_PARAMS_SVH
`define SEG_RST_LIMIT 32'h0000ffff
`define SEG_RST_ATTR 12'h093
`define SEG_RST_CODE_SEL 16'hf000
`define SEG_RST_CODE_BASE 64'h00000000000f0000
`define SEG_REAL_SHIFT 4
`define SEG_REAL_ADDR_W 20
`define SEG_ATTR_DB_BIT 10
`endif

// ### design/seg_xlat_pkg.sv
package seg_xlat_pkg;
  typedef enum logic [3:0] {
    SEG_CODE = 4'h0,
    SEG_DATA = 4'h1,
    SEG_EXTRA = 4'h2,
    SEG_ADD_ONE = 4'h3,
    SEG_ADD_TWO = 4'h4,
    SEG_STACK = 4'h5,
    SEG_GDT = 4'h6,
    SEG_LDT = 4'h7,
    SEG_IDT = 4'h8,
    SEG_TASK = 4'h9
  } seg_idx_t;
  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_PROT = 2'b01,
    MODE_COMPAT = 2'b11,
    MODE_LONG64 = 2'b10
  } cpu_mode_t;
  typedef enum logic [1:0] {
    LOAD_NONE = 2'h0,
    LOAD_SELECTOR = 2'h1,
    LOAD_FAR = 2'h2,
    LOAD_DESCRIPTOR = 2'h3
  } load_kind_t;
endpackage

// ### design/seg_addr_adder.sv
`timescale 1ns/1ns
`include "seg_xlat_params.svh"
module seg_addr_adder
  import seg_xlat_pkg::*;
(
  input wire logic [1:0] mode_in,
  input wire logic [15:0] selector_in,
  input wire logic [63:0] base_in,
  input wire logic [31:0] limit_in,
  input wire logic attr_db_in,
  input wire logic flat_base_in,
  input wire logic [63:0] eff_addr_in,
  output logic [63:0] lin_addr_out,
  output logic limit_fault_out
);
  logic [19:0] real_addr;
  logic [31:0] prot_off;
  logic [31:0] prot_sum;
  always_comb begin
    real_addr = {4'h0, selector_in} * 20'h00010 + {4'h0, eff_addr_in[15:0]};
    prot_off = attr_db_in ? eff_addr_in[31:0] : {16'h0000, eff_addr_in[15:0]};
    prot_sum = base_in[31:0] + prot_off;
    lin_addr_out = 64'h0;
    limit_fault_out = 1'b0;
    unique case (cpu_mode_t'(mode_in))
      MODE_REAL: lin_addr_out = {44'h0, real_addr};
      MODE_PROT, MODE_COMPAT: begin
        lin_addr_out = {32'h0, prot_sum};
        limit_fault_out = prot_off > limit_in;
      end
      MODE_LONG64: lin_addr_out = flat_base_in ? eff_addr_in : base_in + eff_addr_in;
    endcase
  end
endmodule

// ### bench/seg_xlat_chk.sv
`timescale 1ns/1ns
module seg_xlat_chk
  import seg_xlat_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [1:0] load_kind_in,
  input wire logic [3:0] load_seg_in,
  input wire logic [15:0] load_sel_in,
  input wire logic access_in,
  input wire logic [3:0] access_seg_in,
  input wire logic [63:0] eff_addr_in,
  input wire logic [1:0] mode_out,
  input wire logic addr_valid_out,
  input wire logic [63:0] lin_addr_out,
  input wire logic limit_fault_out,
  input wire logic load_err_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence ld_acc;
    load_in && load_kind_in == LOAD_SELECTOR && mode_out == MODE_REAL
      && access_in && access_seg_in == load_seg_in;
  endsequence
  rst_mode_a: assert property ($fell(rst_in) |-> mode_out == MODE_REAL)
    else $error("mode not real after reset");
  real_exit_a: assert property ($past(mode_out) == MODE_REAL && mode_out != MODE_REAL
    |-> mode_out == MODE_PROT) else $error("illegal exit from real mode");
  valid_lat_a: assert property (access_in |=> addr_valid_out)
    else $error("no valid after access");
  valid_src_a: assert property (addr_valid_out |-> $past(access_in))
    else $error("valid without access");
  real_addr_a: assert property (ld_acc |=> lin_addr_out[19:0] ==
    $past({load_sel_in, 4'h0} + 20'(eff_addr_in[15:0]))) else $error("real address wrong");
  real_upper_a: assert property (addr_valid_out && $past(mode_out) == MODE_REAL
    |-> lin_addr_out[63:20] == 44'h0 && !limit_fault_out) else $error("real address too wide");
  err_src_a: assert property (load_err_out |-> $past(load_in))
    else $error("load error without load");
  desc_real_a: assert property (load_in && load_kind_in == LOAD_DESCRIPTOR
    && mode_out == MODE_REAL |=> load_err_out) else $error("descriptor load taken in real");
  flat64_a: assert property (access_in && !load_in && mode_out == MODE_LONG64
    && access_seg_in == SEG_DATA |=> lin_addr_out == $past(eff_addr_in)) else $error("not flat");
endmodule
bind segment_address_translation seg_xlat_chk u_chk (.*);

// ### bench/seg_core_model.sv
`timescale 1ns/1ns
module seg_core_model (
  input wire logic clk_in,
  output logic ld_out,
  output logic [1:0] kind_out,
  output logic [3:0] lseg_out,
  output logic [15:0] sel_out,
  output logic acc_out,
  output logic [3:0] aseg_out,
  output logic [63:0] eff_out,
  output logic mreq_out,
  output logic [1:0] msel_out
);
  initial {ld_out, kind_out, lseg_out, sel_out, acc_out, aseg_out, eff_out, mreq_out, msel_out} = '0;
  // one-cycle request issued at the falling edge
  task automatic go(input logic l, input logic [1:0] k, input logic [3:0] ls,
    input logic [15:0] s, input logic a, input logic [3:0] as, input logic [63:0] e,
    input logic m, input logic [1:0] ms);
    @(negedge clk_in);
    {ld_out, kind_out, lseg_out, sel_out, acc_out, aseg_out, eff_out, mreq_out, msel_out} =
      {l, k, ls, s, a, as, e, m, ms};
    @(negedge clk_in);
    {ld_out, acc_out, mreq_out} = 3'h0;
  endtask
endmodule

// ### bench/segment_address_translation_tb.sv
`timescale 1ns/1ns
module segment_address_translation_tb;
  import seg_xlat_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  int failures = 0;
  int samples_checked = 0;
  logic ld, acc, mreq, lerr, val, flt;
  logic [1:0] k, ms, mo;
  logic [3:0] ls, as;
  logic [15:0] s;
  logic [63:0] e, la;
  always #20 clk_sys_in = ~clk_sys_in;
  seg_core_model M (.clk_in(clk_sys_in), .ld_out(ld), .kind_out(k), .lseg_out(ls), .sel_out(s),
    .acc_out(acc), .aseg_out(as), .eff_out(e), .mreq_out(mreq), .msel_out(ms));
  segment_address_translation DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_req_in(mreq),
    .mode_sel_in(ms), .load_in(ld), .load_kind_in(k), .load_seg_in(ls), .load_sel_in(s),
    .load_base_in(64'h0), .load_limit_in(32'h0), .load_attr_in(12'h0), .access_in(acc),
    .access_seg_in(as), .eff_addr_in(e), .mode_out(mo), .addr_valid_out(val),
    .lin_addr_out(la), .limit_fault_out(flt), .load_err_out(lerr));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rl(input logic [1:0] kd, input logic [3:0] sg, input logic [15:0] sl,
    input logic [15:0] of, input logic [63:0] x);
    M.go(1'b1, kd, sg, sl, 1'b1, sg, {48'h0, of}, 1'b0, 2'h0);
    chk(la, x);
    chk({val, flt, lerr}, 3'h4);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b1, sg, {48'h0, of}, 1'b0, 2'h0);
    chk(la, x);
  endtask
  task t_reset;
    chk(mo, MODE_REAL);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b1, SEG_CODE, 64'h4, 1'b0, 2'h0);
    chk(la, 64'hf0004);
  endtask
  task t_loads;
    rl(LOAD_SELECTOR, SEG_DATA, 16'h1234, 16'h0010, 64'h12350);
    rl(LOAD_SELECTOR, SEG_STACK, 16'h0001, 16'h0000, 64'h10);
    rl(LOAD_FAR, SEG_CODE, 16'h2000, 16'h0008, 64'h20008);
    rl(LOAD_SELECTOR, SEG_DATA, 16'hffff, 16'hffff, 64'h0ffef);
  endtask
  task t_modes;
    M.go(1'b1, LOAD_DESCRIPTOR, SEG_GDT, 16'h8, 1'b0, 4'h0, 64'h0, 1'b0, 2'h0);
    chk(lerr, 1'b1);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b0, 4'h0, 64'h0, 1'b1, MODE_LONG64);
    chk(mo, MODE_REAL);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b1, SEG_DATA, 64'h10000, 1'b1, MODE_PROT);
    chk(mo, MODE_PROT);
    M.go(1'b1, LOAD_DESCRIPTOR, SEG_DATA, 16'h8, 1'b1, SEG_DATA, 64'h10, 1'b1, MODE_COMPAT);
    chk({val, flt}, 2'h3);
    chk(la, 64'h10);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b0, 4'h0, 64'h0, 1'b1, MODE_LONG64);
    M.go(1'b0, 2'h0, 4'h0, 16'h0, 1'b1, SEG_DATA, 64'h123456789abcdef0, 1'b0, 2'h0);
    chk(la, 64'h123456789abcdef0);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_reset();
    t_loads();
    t_modes();
    tally_and_finish();
  end
endmodule
